// ===== hw/ursf_pkg.sv
package ursf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RXDATA = 8'h04;
  localparam logic [7:0] ADDR_FORMAT = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0C;
  localparam logic [7:0] ADDR_INT_STAT = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions of uart_status_control
  // ----------------------------------------------------------------
  localparam int BIT_ADDR_DET = 5;
  localparam int BIT_RX_IDLE = 4;
  localparam int BIT_PAR_ERR = 3;
  localparam int BIT_FRM_ERR = 2;
  localparam int BIT_OVR_ERR = 1;
  localparam int BIT_RXDA = 0;

  // ----------------------------------------------------------------
  // Frame formats
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_9N = 2'h3;

  // ----------------------------------------------------------------
  // Interrupt event bits
  // ----------------------------------------------------------------
  localparam int EV_RXCHAR = 0;
  localparam int EV_PAR_ERR = 1;
  localparam int EV_FRM_ERR = 2;
  localparam int EV_OVR_ERR = 3;
  localparam int EV_W = 4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] BAUD_RST = 16'h06C8;
  localparam logic [1:0] FMT_RST = FMT_8N;
  localparam logic ADDR_DET_RST = 1'b0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

endpackage

// ===== hw/ursf_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Address detect acts only in 9-bit frames
// - Idle flag high unless a character arrives
// - Parity flag reflects head FIFO character
// - Framing flag reflects head FIFO character
// - Overrun set on arrival into full buffer
// - Clearing overrun flushes buffer and shift register
// - Data-available high while buffer holds characters
module ursf_top
  import ursf_pkg::*;
#(
  parameter int DEPTH = 4
)
(
  input wire logic SYS_CLK, // 200 MHz clock
  input wire logic SRST, // Synchronous reset, active high
  input wire logic RXD, // Serial receive pin, idle high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  output logic IRQ // Level interrupt
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ursf_rx_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    ursf_rx_t st;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic par_bit;
    logic [DEPTH-1:0][10:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic addr_det;
    logic [1:0] mode;
    logic [15:0] baud;
    logic ovr_err;
    logic [EV_W-1:0] int_stat;
    logic [EV_W-1:0] int_mask;
    logic [31:0] prdata;
    logic pslverr;
    logic pop_pend;
  } ursf_state_t;

  ursf_state_t r;
  ursf_state_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] bit_time(input logic [15:0] b);
    bit_time = (b == 16'h0000) ? 16'h0000 : b - 16'h0001;
  endfunction

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction

  logic setup;
  logic access;
  logic mode9;
  logic has_par;
  logic done;
  logic discard;
  logic full;
  logic par_err_c;
  logic frm_err_c;
  logic ovf_evt;
  logic ovr_clr;
  logic push;
  logic pop;
  logic rxda;
  logic receiver_idle_flag;
  logic [10:0] head;
  logic stat_par_err;
  logic stat_frm_err;
  logic mapped;
  logic [31:0] status_word;
  logic [31:0] rdata_c;
  logic [EV_W-1:0] ev;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign mode9 = (r.mode == FMT_9N);
  assign has_par = (r.mode == FMT_8E) || (r.mode == FMT_8O);
  assign done = (r.st == RX_STOP) && (r.cnt == 16'h0000);
  assign discard = r.addr_det && mode9 && !r.sh[8];
  assign full = (r.count == DEPTH_C);
  assign par_err_c = has_par && ((^r.sh[7:0] ^ r.par_bit) != (r.mode == FMT_8O));
  assign frm_err_c = !r.sync2;
  assign ovf_evt = done && !discard && full;
  // A clear that meets a new overrun is ignored, so the overrun is kept
  assign ovr_clr = access && PWRITE && is_reg(PADDR, ADDR_STATUS) && !PWDATA[BIT_OVR_ERR]
    && r.ovr_err && !ovf_evt;
  assign push = done && !discard && !full && !ovr_clr;
  assign pop = access && !PWRITE && is_reg(PADDR, ADDR_RXDATA) && r.pop_pend;
  assign rxda = (r.count != '0);
  assign receiver_idle_flag = (r.st == RX_IDLE);
  assign head = r.mem[r.rp];
  assign stat_par_err = rxda && head[10];
  assign stat_frm_err = rxda && head[9];
  assign ev = {ovf_evt, push && frm_err_c, push && par_err_c, push};

  assign mapped = is_reg(PADDR, ADDR_STATUS) || is_reg(PADDR, ADDR_RXDATA)
    || is_reg(PADDR, ADDR_FORMAT) || is_reg(PADDR, ADDR_BAUD)
    || is_reg(PADDR, ADDR_INT_STAT) || is_reg(PADDR, ADDR_INT_MASK);

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[BIT_ADDR_DET] = r.addr_det;
    status_word[BIT_RX_IDLE] = receiver_idle_flag;
    status_word[BIT_PAR_ERR] = stat_par_err;
    status_word[BIT_FRM_ERR] = stat_frm_err;
    status_word[BIT_OVR_ERR] = r.ovr_err;
    status_word[BIT_RXDA] = rxda;
    case (PADDR)
      ADDR_STATUS: rdata_c = status_word;
      ADDR_RXDATA: rdata_c = rxda ? {23'h000000, head[8:0]} : 32'h0000_0000;
      ADDR_FORMAT: rdata_c = {30'h0000_0000, r.mode};
      ADDR_BAUD: rdata_c = {16'h0000, r.baud};
      ADDR_INT_STAT: rdata_c = {28'h000_0000, r.int_stat};
      ADDR_INT_MASK: rdata_c = {28'h000_0000, r.int_mask};
      default: rdata_c = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.sync1 = RXD;
    n.sync2 = r.sync1;

    // Receiver: one counter paces half a bit to the start centre, then whole bits
    case (r.st)
      RX_IDLE:
      begin
        if (!r.sync2)
        begin
          n.st = RX_START;
          n.cnt = r.baud >> 1;
          n.sh = '0;
        end
      end
      RX_START:
      begin
        if (r.cnt != 16'h0000)
          n.cnt = r.cnt - 16'h0001;
        else if (!r.sync2)
        begin
          n.st = RX_DATA;
          n.cnt = bit_time(r.baud);
          n.bitn = 4'h0;
        end
        else
          n.st = RX_IDLE;
      end
      RX_DATA:
      begin
        if (r.cnt != 16'h0000)
          n.cnt = r.cnt - 16'h0001;
        else
        begin
          n.sh[r.bitn] = r.sync2;
          n.cnt = bit_time(r.baud);
          n.bitn = r.bitn + 4'h1;
          if (r.bitn == (mode9 ? 4'h8 : 4'h7))
            n.st = has_par ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR:
      begin
        if (r.cnt != 16'h0000)
          n.cnt = r.cnt - 16'h0001;
        else
        begin
          n.par_bit = r.sync2;
          n.cnt = bit_time(r.baud);
          n.st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (r.cnt != 16'h0000)
          n.cnt = r.cnt - 16'h0001;
        else
          n.st = RX_IDLE;
      end
      default: n.st = RX_IDLE;
    endcase

    // Receive buffer
    if (push)
    begin
      n.mem[r.wp] = {par_err_c, frm_err_c, r.sh};
      n.wp = ptr_inc(r.wp);
    end
    if (pop)
      n.rp = ptr_inc(r.rp);
    n.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);

    n.ovr_err = ovf_evt || (r.ovr_err && !ovr_clr);
    if (ovr_clr)
    begin
      // Flush drops the character in flight too, so a partial frame is not kept
      n.wp = '0;
      n.rp = '0;
      n.count = '0;
      n.st = RX_IDLE;
      n.sh = '0;
      n.cnt = 16'h0000;
      n.bitn = 4'h0;
    end

    // APB: read data is captured in the setup cycle, pop happens at the access edge
    if (setup)
    begin
      n.prdata = rdata_c;
      n.pslverr = !mapped;
      n.pop_pend = !PWRITE && is_reg(PADDR, ADDR_RXDATA) && rxda;
    end

    n.int_stat = r.int_stat | ev;
    if (access && PWRITE)
    begin
      case (PADDR)
        ADDR_STATUS: n.addr_det = PWDATA[BIT_ADDR_DET];
        ADDR_FORMAT: n.mode = PWDATA[1:0];
        ADDR_BAUD: n.baud = PWDATA[15:0];
        ADDR_INT_STAT: n.int_stat = (r.int_stat & ~PWDATA[EV_W-1:0]) | ev;
        ADDR_INT_MASK: n.int_mask = PWDATA[EV_W-1:0];
        default: n.int_mask = r.int_mask;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      r <= '0;
      r.sync1 <= 1'b1;
      r.sync2 <= 1'b1;
      r.st <= RX_IDLE;
      r.baud <= BAUD_RST;
      r.mode <= FMT_RST;
      r.addr_det <= ADDR_DET_RST;
      r.int_mask <= MASK_RST;
    end
    else
      r <= n;
  end

  assign PRDATA = r.prdata;
  assign PSLVERR = r.pslverr;
  assign PREADY = access;
  assign IRQ = |(r.int_stat & r.int_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_start_seen;
    (r.st == RX_IDLE) && !r.sync2 && !ovr_clr;
  endsequence

  sequence s_into_empty;
    push && (r.count == '0);
  endsequence

  sequence s_char_kept;
    done && !discard && !full && !ovr_clr;
  endsequence

  a_addr_drop: assert property (done && discard && !pop && !ovr_clr |=>
    (r.count == $past(r.count)))
    else $error("address mode stored a data character");

  a_addr_noeffect: assert property (done && !mode9 && !full && !ovr_clr && !pop |=>
    (r.count == $past(r.count) + (AW + 1)'(1)))
    else $error("character lost outside 9-bit mode");

  a_idle_drop: assert property (s_start_seen |=> !receiver_idle_flag)
    else $error("idle flag still high after start bit");

  a_idle_return: assert property (done |=> receiver_idle_flag)
    else $error("receiver not idle after stop bit");

  a_par_head: assert property (s_into_empty ##0 par_err_c |=> stat_par_err)
    else $error("parity flag missing for head character");

  a_par_clean: assert property (s_into_empty ##0 !par_err_c |=> !stat_par_err)
    else $error("parity flag set for good character");

  a_frm_head: assert property (s_into_empty ##0 !frm_err_c |=> !stat_frm_err)
    else $error("framing flag set for good character");

  a_frm_seen: assert property (s_into_empty ##0 frm_err_c |=> stat_frm_err)
    else $error("framing flag missing for head character");

  a_ovr_set: assert property (done && !discard && full && !pop |=>
    r.ovr_err && (r.count == DEPTH_C))
    else $error("overrun not flagged");

  a_ovr_hold: assert property (r.ovr_err && !ovr_clr |=> r.ovr_err)
    else $error("overrun flag dropped without a clear");

  a_ovr_no_sw: assert property (!r.ovr_err && !ovf_evt |=> !r.ovr_err)
    else $error("overrun flag set without an overrun");

  a_ovr_event: assert property (ovf_evt |=> r.int_stat[EV_OVR_ERR])
    else $error("overrun event not recorded");

  // Idle is checked one cycle only: the line may open a new frame right after the flush
  a_ovr_flush: assert property (ovr_clr |=>
    (!r.ovr_err && !rxda && receiver_idle_flag) ##1 (!r.ovr_err && !rxda))
    else $error("overrun clear did not flush receiver");

  a_rxda_kept: assert property (s_char_kept |=> rxda)
    else $error("data available missing after a stored character");

  a_rxda_last: assert property (pop && (r.count == (AW + 1)'(1)) && !push |=> !rxda)
    else $error("data available after last character read");

endmodule

// ===== test/ursf_uart_tx.sv
`timescale 1ns/1ps
module ursf_uart_tx
(
  input wire logic clk, // Bit timing clock
  output logic txd // Serial line, idle high
);
  int baud = 8;

  initial txd = 1'b1;

  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  // Start, data LSB first, optional parity, one stop, one idle bit;
  // bad_par and stp corrupt a frame only when a scenario asks
  task automatic send(input logic [8:0] d, input int nb, input int par,
    input logic bad_par, input logic stp);
    logic b[$];
    b.push_back(1'b0);
    for (int i = 0; i < nb; i++)
      b.push_back(d[i]);
    if (par != 0)
      b.push_back(^d[7:0] ^ (par == 2) ^ bad_par);
    b.push_back(stp);
    b.push_back(1'b1);
    foreach (b[i])
    begin
      @(posedge clk);
      txd <= b[i];
      repeat (baud - 1) @(posedge clk);
    end
  endtask
endmodule

// ===== test/tb_uart_receive_status_flags.sv
`timescale 1ns/1ps
module tb_uart_receive_status_flags
  import ursf_pkg::*;
;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic RXD;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic IRQ;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] q;
  logic err;

  always #2.5 SYS_CLK = ~SYS_CLK;

  ursf_uart_tx tx (.clk(SYS_CLK), .txd(RXD));

  ursf_top #(.DEPTH(4)) dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .RXD(RXD), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until PREADY is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1)
      @(posedge SYS_CLK);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic irq_is(input logic v);
    @(negedge SYS_CLK);
    chk({31'h0, IRQ}, {31'h0, v});
  endtask

  // Ceiling well above the roughly 1400 cycles the sequence needs
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    rd(ADDR_STATUS, 32'h10);
    rd(ADDR_BAUD, {16'h0, BAUD_RST});
    wr(ADDR_STATUS, 32'h2);
    rd(ADDR_STATUS, 32'h10);
    rd(8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(ADDR_BAUD, 32'h8);
    fork
      tx.send(9'h0A5, 8, 0, 1'b0, 1'b1);
      begin
        repeat (30) @(posedge SYS_CLK);
        rd(ADDR_STATUS, 32'h0);
      end
    join
    rd(ADDR_STATUS, 32'h11);
    rd(ADDR_RXDATA, 32'hA5);
    rd(ADDR_STATUS, 32'h10);
    for (int m = 0; m < 3; m++)
    begin
      wr(ADDR_FORMAT, 32'(m));
      tx.send(9'h03C + 9'(m), 8, m, 1'b0, 1'b1);
      rd(ADDR_STATUS, 32'h11);
      rd(ADDR_RXDATA, 32'h3C + 32'(m));
    end
    wr(ADDR_FORMAT, {30'h0, FMT_8E});
    tx.send(9'h011, 8, 1, 1'b1, 1'b1);
    tx.send(9'h022, 8, 1, 1'b0, 1'b0);
    rd(ADDR_STATUS, 32'h19);
    rd(ADDR_RXDATA, 32'h11);
    rd(ADDR_STATUS, 32'h15);
    rd(ADDR_RXDATA, 32'h22);
    rd(ADDR_STATUS, 32'h10);
    rd(ADDR_INT_STAT, 32'h7);
    wr(ADDR_FORMAT, {30'h0, FMT_8N});
    wr(ADDR_INT_STAT, 32'hF);
    for (int k = 0; k < 5; k++)
      tx.send(9'h040 + 9'(k), 8, 0, 1'b0, 1'b1);
    rd(ADDR_STATUS, 32'h13);
    rd(ADDR_INT_STAT, 32'h9);
    irq_is(1'b0);
    wr(ADDR_INT_MASK, 32'h8);
    irq_is(1'b1);
    wr(ADDR_STATUS, 32'h2);
    rd(ADDR_STATUS, 32'h13);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS, 32'h10);
    rd(ADDR_RXDATA, 32'h0);
    wr(ADDR_INT_STAT, 32'h8);
    irq_is(1'b0);
    wr(ADDR_FORMAT, {30'h0, FMT_9N});
    wr(ADDR_STATUS, 32'h20);
    tx.send(9'h055, 9, 0, 1'b0, 1'b1);
    tx.send(9'h1A5, 9, 0, 1'b0, 1'b1);
    rd(ADDR_STATUS, 32'h31);
    rd(ADDR_RXDATA, 32'h1A5);
    rd(ADDR_STATUS, 32'h30);
    wr(ADDR_FORMAT, {30'h0, FMT_8N});
    tx.send(9'h055, 8, 0, 1'b0, 1'b1);
    rd(ADDR_RXDATA, 32'h55);
    // Mid-run reset: address detect, event bits and divisor must return to reset values
    SRST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    rd(ADDR_STATUS, 32'h10);
    rd(ADDR_INT_STAT, 32'h0);
    rd(ADDR_BAUD, {16'h0, BAUD_RST});
    report_and_stop();
  end
endmodule
